//--- wumc_regs.sv
// wake-up measurement compare registers with amplitude and phase channels
// Function
// - display registers clear at reset and set-default
// - amplitude average readable at 34h
// - amplitude result readable at 35h, writes ignored
// - phase threshold in config bits 7:4
// - config bit 3 includes triggering sample
// - bits 2:1 pick weight 4,8,16,32
// - bit 0 picks average or fixed reference
// - phase fixed reference read-write at 37h
// - config and reference zero after defaults
// - phase average readable at 38h
// - phase result readable at 39h
// - 3Ah to 3Dh reserved, read only
// - timer expiry starts phase compare
// - timer expiry starts amplitude compare
`timescale 1ns/1ps
module wumc_regs (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       set_default,
  input  wire logic       timer_expired,
  input  wire logic       wake_amp_en,
  input  wire logic       wake_phase_en,
  input  wire logic [7:0] amp_cfg,
  input  wire logic [7:0] amp_ref,
  input  wire logic       amp_meas_valid,
  input  wire logic [7:0] amp_meas_data,
  input  wire logic       phase_meas_valid,
  input  wire logic [7:0] phase_meas_data,
  output logic            amp_meas_start,
  output logic            phase_meas_start,
  output logic            amp_irq,
  output logic            phase_irq
);

  typedef struct packed {
    logic [7:0] phase_cfg;
    logic [7:0] phase_ref;
    logic [7:0] rdata;
  } wumc_regs_s;

  wumc_regs_s state;
  wumc_regs_s next_state;

  logic [7:0] amp_avg;
  logic [7:0] amp_res;
  logic [7:0] ph_avg;
  logic [7:0] ph_res;
  logic       amp_wait;
  logic       ph_wait;
  logic       amp_trig;
  logic       ph_trig;

  ////////////////////////////////////////////////////////////////////////////
  // wake-up triggers: a measurement runs only when its enable is set
  assign amp_trig = timer_expired && wake_amp_en;
  assign ph_trig  = timer_expired && wake_phase_en;

  ////////////////////////////////////////////////////////////////////////////
  // amplitude channel: its config and reference live outside this block
  wumc_chan u_amp (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .clk_en       (clk_en),
    .clear        (set_default),
    .trigger      (amp_trig),
    .meas_valid   (amp_meas_valid),
    .meas_data    (amp_meas_data),
    .threshold    (amp_cfg[wumc_pkg::THR_MSB:wumc_pkg::THR_LSB]),
    .include_trig (amp_cfg[wumc_pkg::INCL_BIT]),
    .weight_sel   (amp_cfg[wumc_pkg::WSEL_MSB:wumc_pkg::WSEL_LSB]),
    .use_avg      (amp_cfg[wumc_pkg::USEAVG_BIT]),
    .fixed_ref    (amp_ref),
    .meas_start   (amp_meas_start),
    .waiting      (amp_wait),
    .irq          (amp_irq),
    .result       (amp_res),
    .average      (amp_avg)
  );

  // phase channel steered by the local config and reference registers
  wumc_chan u_phase (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .clk_en       (clk_en),
    .clear        (set_default),
    .trigger      (ph_trig),
    .meas_valid   (phase_meas_valid),
    .meas_data    (phase_meas_data),
    .threshold    (state.phase_cfg[wumc_pkg::THR_MSB:wumc_pkg::THR_LSB]),
    .include_trig (state.phase_cfg[wumc_pkg::INCL_BIT]),
    .weight_sel   (state.phase_cfg[wumc_pkg::WSEL_MSB:wumc_pkg::WSEL_LSB]),
    .use_avg      (state.phase_cfg[wumc_pkg::USEAVG_BIT]),
    .fixed_ref    (state.phase_ref),
    .meas_start   (phase_meas_start),
    .waiting      (ph_wait),
    .irq          (phase_irq),
    .result       (ph_res),
    .average      (ph_avg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes and registered read data
  always_comb begin
    next_state = state;
    if (reg_wr) begin
      unique case (reg_addr)
        wumc_pkg::PH_CFG_OFS: next_state.phase_cfg = reg_wdata;
        wumc_pkg::PH_REF_OFS: next_state.phase_ref = reg_wdata;
        // display and reserved offsets are read only
        default:              next_state.phase_cfg = state.phase_cfg;
      endcase
    end
    // set-default wins over a write in the same cycle
    if (set_default) begin
      next_state.phase_cfg = wumc_pkg::CFG_RST;
      next_state.phase_ref = wumc_pkg::REF_RST;
    end
    // read data holds between reads so the serial shifter can take its time
    if (reg_rd) begin
      unique case (reg_addr)
        wumc_pkg::AMP_AVG_OFS: next_state.rdata = amp_avg;
        wumc_pkg::AMP_RES_OFS: next_state.rdata = amp_res;
        wumc_pkg::PH_CFG_OFS:  next_state.rdata = state.phase_cfg;
        wumc_pkg::PH_REF_OFS:  next_state.rdata = state.phase_ref;
        wumc_pkg::PH_AVG_OFS:  next_state.rdata = ph_avg;
        wumc_pkg::PH_RES_OFS:  next_state.rdata = ph_res;
        wumc_pkg::RSVD_A_OFS,
        wumc_pkg::RSVD_B_OFS,
        wumc_pkg::RSVD_C_OFS,
        wumc_pkg::RSVD_D_OFS:  next_state.rdata = wumc_pkg::RSVD_READ;
        default:               next_state.rdata = wumc_pkg::UNMAPPED;
      endcase
    end
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks: helper references seen by the phase and amplitude compares
  logic [7:0] ph_sel_ref;
  assign ph_sel_ref = state.phase_cfg[wumc_pkg::USEAVG_BIT] ? ph_avg : state.phase_ref;
  logic [7:0] amp_sel_ref;
  assign amp_sel_ref = amp_cfg[wumc_pkg::USEAVG_BIT] ? amp_avg : amp_ref;

  AST_DEFAULT_CLEARS: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && set_default |=> state.phase_cfg == 8'h00 && state.phase_ref == 8'h00
      && amp_avg == 8'h00 && amp_res == 8'h00 && ph_avg == 8'h00 && ph_res == 8'h00)
    else $error("set-default left a register non-zero");

  AST_AMP_AVG_READ: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == 6'h34 |=> reg_rdata == $past(amp_avg))
    else $error("amplitude average read wrong");

  AST_AMP_RES_RO: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == 6'h35 && !amp_meas_valid && !set_default
      |=> $stable(amp_res))
    else $error("write changed amplitude result");

  AST_AMP_RES_TAKE: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && amp_meas_valid && !set_default |=> amp_res == $past(amp_meas_data))
    else $error("amplitude result not captured");

  AST_PH_THRESHOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && ph_wait && phase_meas_valid && !set_default
      |=> phase_irq == (wumc_pkg::abs_diff($past(phase_meas_data), $past(ph_sel_ref))
                        > {4'h0, $past(state.phase_cfg[7:4])}))
    else $error("phase interrupt disagrees with threshold");

  AST_PH_EXCLUDE: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && ph_wait && phase_meas_valid && !set_default && !state.phase_cfg[3]
      && wumc_pkg::abs_diff(phase_meas_data, ph_sel_ref) > {4'h0, state.phase_cfg[7:4]}
      |=> $stable(ph_avg))
    else $error("excluded sample entered the average");

  AST_PH_AVG_STEP: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && ph_wait && phase_meas_valid && !set_default
      && (state.phase_cfg[3]
          || wumc_pkg::abs_diff(phase_meas_data, ph_sel_ref) <= {4'h0, state.phase_cfg[7:4]})
      |=> ph_avg == wumc_pkg::avg_step($past(ph_avg), $past(phase_meas_data),
                                       $past(state.phase_cfg[2:1])))
    else $error("phase average step wrong");

  AST_REF_WRITE: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == 6'h37 && !set_default
      ##1 clk_en && reg_rd && reg_addr == 6'h37 && !reg_wr && !set_default
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("phase reference did not read back");

  AST_PH_AVG_READ: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == 6'h38 |=> reg_rdata == $past(ph_avg))
    else $error("phase average read wrong");

  AST_PH_RES: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && phase_meas_valid && !set_default ##1 clk_en && reg_rd && reg_addr == 6'h39
      && !phase_meas_valid && !set_default |=> reg_rdata == $past(phase_meas_data, 2))
    else $error("phase result read wrong");

  AST_RSVD_READ: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr inside {[6'h3a:6'h3d]} |=> reg_rdata == 8'h00)
    else $error("reserved location read non-zero");

  AST_PH_START: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && timer_expired && wake_phase_en && !set_default |=> phase_meas_start && ph_wait)
    else $error("phase measurement not started");

  AST_AMP_START: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && timer_expired && wake_amp_en && !set_default |=> amp_meas_start && amp_wait)
    else $error("amplitude measurement not started");

  AST_NO_SPURIOUS_START: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !(timer_expired && wake_phase_en) |=> !phase_meas_start)
    else $error("phase start without timer expiry");

  AST_AMP_THRESHOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && amp_wait && amp_meas_valid && !set_default
      |=> amp_irq == (wumc_pkg::abs_diff($past(amp_meas_data), $past(amp_sel_ref))
                      > {4'h0, $past(amp_cfg[7:4])}))
    else $error("amplitude interrupt disagrees with threshold");

  AST_AMP_EXCLUDE: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && amp_wait && amp_meas_valid && !set_default && !amp_cfg[3]
      && wumc_pkg::abs_diff(amp_meas_data, amp_sel_ref) > {4'h0, amp_cfg[7:4]}
      |=> $stable(amp_avg))
    else $error("excluded amplitude sample entered the average");

  AST_AMP_AVG_BOUND: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && amp_wait && amp_meas_valid && !set_default
      |=> ($past(amp_meas_data) >= $past(amp_avg))
          ? (amp_avg >= $past(amp_avg) && amp_avg <= $past(amp_meas_data))
          : (amp_avg <= $past(amp_avg) && amp_avg >= $past(amp_meas_data)))
    else $error("amplitude average left the span of old value and sample");

  AST_PH_AVG_BOUND: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && ph_wait && phase_meas_valid && !set_default
      |=> ($past(phase_meas_data) >= $past(ph_avg))
          ? (ph_avg >= $past(ph_avg) && ph_avg <= $past(phase_meas_data))
          : (ph_avg <= $past(ph_avg) && ph_avg >= $past(phase_meas_data)))
    else $error("phase average left the span of old value and sample");

  AST_PH_IRQ_PENDING: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !(ph_wait && phase_meas_valid) |=> !phase_irq)
    else $error("phase interrupt without a requested sample");

  AST_AMP_IRQ_PENDING: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !(amp_wait && amp_meas_valid) |=> !amp_irq)
    else $error("amplitude interrupt without a requested sample");

  AST_PH_AVG_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !(ph_wait && phase_meas_valid) && !set_default |=> $stable(ph_avg))
    else $error("phase average moved without a counted sample");

  AST_AMP_AVG_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !(amp_wait && amp_meas_valid) && !set_default |=> $stable(amp_avg))
    else $error("amplitude average moved without a counted sample");

  AST_PH_RES_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !phase_meas_valid && !set_default |=> $stable(ph_res))
    else $error("phase result moved without a sample");

  AST_CFG_READ: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == 6'h36 |=> reg_rdata == $past(state.phase_cfg))
    else $error("phase config read wrong");

  AST_REF_READ: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == 6'h37 |=> reg_rdata == $past(state.phase_ref))
    else $error("phase reference read wrong");

  AST_CFG_WRITE: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == 6'h36 && !set_default
      |=> state.phase_cfg == $past(reg_wdata))
    else $error("phase config write did not land");

  AST_RO_WRITE_IGNORED: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr != 6'h36 && reg_addr != 6'h37 && !set_default
      |=> $stable(state.phase_cfg) && $stable(state.phase_ref))
    else $error("write to a read-only offset changed a register");

  AST_RDATA_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  AST_FREEZE: assert property (
    @(posedge sys_clk) disable iff (rst)
    !clk_en |=> $stable(state) && $stable(amp_res) && $stable(amp_avg)
      && $stable(ph_res) && $stable(ph_avg) && $stable(amp_wait) && $stable(ph_wait))
    else $error("state moved while the clock enable was low");

  AST_ABORT_PENDING: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && set_default
      |=> !ph_wait && !amp_wait && !phase_meas_start && !amp_meas_start && !phase_irq)
    else $error("set-default left a measurement pending");

  AST_PH_PENDING_DONE: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && ph_wait && phase_meas_valid && !ph_trig && !set_default
      |=> !ph_wait && !phase_meas_start)
    else $error("phase compare stayed pending after its sample");

  AST_UNMAPPED_READ: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && reg_rd && (reg_addr < 6'h34 || reg_addr > 6'h3d) |=> reg_rdata == 8'h00)
    else $error("unmapped location read non-zero");

endmodule // wumc_regs

//--- wumc_pkg.sv
// shared constants and helpers for the wake-up measurement compare registers
package wumc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the host serial port
  localparam logic [5:0] AMP_AVG_OFS   = 6'h34;
  localparam logic [5:0] AMP_RES_OFS   = 6'h35;
  localparam logic [5:0] PH_CFG_OFS    = 6'h36;
  localparam logic [5:0] PH_REF_OFS    = 6'h37;
  localparam logic [5:0] PH_AVG_OFS    = 6'h38;
  localparam logic [5:0] PH_RES_OFS    = 6'h39;
  localparam logic [5:0] RSVD_A_OFS    = 6'h3a;
  localparam logic [5:0] RSVD_B_OFS    = 6'h3b;
  localparam logic [5:0] RSVD_C_OFS    = 6'h3c;
  localparam logic [5:0] RSVD_D_OFS    = 6'h3d;

  ////////////////////////////////////////////////////////////////////////////
  // configuration field positions (same layout for both channels)
  localparam int THR_MSB    = 7;
  localparam int THR_LSB    = 4;
  localparam int INCL_BIT   = 3;
  localparam int WSEL_MSB   = 2;
  localparam int WSEL_LSB   = 1;
  localparam int USEAVG_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset or set-default, and fixed read values
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] REF_RST   = 8'h00;
  localparam logic [7:0] DISP_RST  = 8'h00;
  localparam logic [7:0] RSVD_READ = 8'h00;
  localparam logic [7:0] UNMAPPED  = 8'h00;
  // weight code 00 means divide by 4, so shift = code + 2
  localparam logic [2:0] WEIGHT_SHIFT_BASE = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // magnitude of the distance between a sample and its reference
  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction

  // one running-average step: avg + (meas - avg) / weight
  function automatic logic [7:0] avg_step(input logic [7:0] avg, input logic [7:0] meas,
                                          input logic [1:0] wsel);
    logic signed [8:0] d;
    logic signed [8:0] s;
    d = $signed({1'b0, meas}) - $signed({1'b0, avg});
    s = d >>> ({1'b0, wsel} + WEIGHT_SHIFT_BASE);
    // result lies between avg and meas, so the 8-bit wrap is exact
    return 8'(avg + s[7:0]);
  endfunction

endpackage

//--- wumc_chan.sv
// one wake-up measurement channel: compare, running average, display values
`timescale 1ns/1ps
module wumc_chan (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       clear,
  input  wire logic       trigger,
  input  wire logic       meas_valid,
  input  wire logic [7:0] meas_data,
  input  wire logic [3:0] threshold,
  input  wire logic       include_trig,
  input  wire logic [1:0] weight_sel,
  input  wire logic       use_avg,
  input  wire logic [7:0] fixed_ref,
  output logic            meas_start,
  output logic            waiting,
  output logic            irq,
  output logic [7:0]      result,
  output logic [7:0]      average
);

  typedef struct packed {
    logic       pending;
    logic       start;
    logic       irq;
    logic [7:0] result;
    logic [7:0] average;
  } wumc_chan_s;

  wumc_chan_s state;
  wumc_chan_s next_state;
  logic [7:0] ref_val;
  logic       over;

  ////////////////////////////////////////////////////////////////////////////
  // next state: clear beats everything, then trigger, then evaluation
  always_comb begin
    next_state       = state;
    next_state.start = 1'b0;
    next_state.irq   = 1'b0;
    ref_val = use_avg ? state.average : fixed_ref;
    // either direction of drift counts
    over = wumc_pkg::abs_diff(meas_data, ref_val) > {4'h0, threshold};
    if (meas_valid) begin
      next_state.result = meas_data;
    end
    // only a sample asked for by the wake-up timer is compared and averaged
    if (state.pending && meas_valid) begin
      next_state.pending = 1'b0;
      next_state.irq     = over;
      if (!over || include_trig) begin
        next_state.average = wumc_pkg::avg_step(state.average, meas_data, weight_sel);
      end
    end
    if (trigger) begin
      next_state.pending = 1'b1;
      next_state.start   = 1'b1;
    end
    // set-default aborts a pending compare too
    if (clear) begin
      next_state.pending = 1'b0;
      next_state.start   = 1'b0;
      next_state.irq     = 1'b0;
      next_state.result  = wumc_pkg::DISP_RST;
      next_state.average = wumc_pkg::DISP_RST;
    end
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign meas_start = state.start;
  assign waiting    = state.pending;
  assign irq        = state.irq;
  assign result     = state.result;
  assign average    = state.average;

endmodule // wumc_chan

//--- wumc_regs_tb.sv
// self-checking bench for the wake-up measurement compare registers
`timescale 1ns/1ps
module wumc_regs_tb;
  logic       sys_clk, rst, clk_en, reg_wr, reg_rd, set_default, timer_expired;
  logic       wake_amp_en, wake_phase_en, amp_meas_valid, phase_meas_valid;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, amp_cfg, amp_ref, amp_meas_data, phase_meas_data;
  logic       amp_meas_start, phase_meas_start, amp_irq, phase_irq;
  int         miscompares, checks_done;
  // reference model state, index 0 amplitude, 1 phase
  logic [7:0] m_avg [2];
  logic [7:0] m_res [2];
  logic [7:0] m_cfg [2];
  logic [7:0] m_ref [2];

  wumc_regs uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .set_default(set_default), .timer_expired(timer_expired), .wake_amp_en(wake_amp_en),
    .wake_phase_en(wake_phase_en), .amp_cfg(amp_cfg), .amp_ref(amp_ref),
    .amp_meas_valid(amp_meas_valid), .amp_meas_data(amp_meas_data),
    .phase_meas_valid(phase_meas_valid), .phase_meas_data(phase_meas_data),
    .amp_meas_start(amp_meas_start), .phase_meas_start(phase_meas_start),
    .amp_irq(amp_irq), .phase_irq(phase_irq));

  ////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // expected average step, signed so the shift floors toward minus infinity
  function automatic logic [7:0] nxt_avg(logic [7:0] a, logic [7:0] s, logic [1:0] w);
    int d;
    d = int'(s) - int'(a);
    d = d >>> (int'(w) + 2);
    return 8'(int'(a) + d);
  endfunction

  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(string nm, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // register port tasks, all entered and left at a falling edge
  task automatic wr(logic [5:0] a, logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // sampled a cycle late: read data holds until the next read anyway
  task automatic rdchk(string nm, logic [5:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    chk8(nm, e, reg_rdata);
  endtask

  task automatic set_phase_cfg(logic [7:0] c, logic [7:0] r);
    wr(wumc_pkg::PH_CFG_OFS, c);
    // idle edge so the write strobe is never lowered and raised at once
    @(negedge sys_clk);
    wr(wumc_pkg::PH_REF_OFS, r);
    m_cfg[1] = c;
    m_ref[1] = r;
    // reference read right behind its write
    rdchk("phase_fixed_reference", wumc_pkg::PH_REF_OFS, r);
    rdchk("phase_detect_config", wumc_pkg::PH_CFG_OFS, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one measurement on channel ch, timer-requested when pend is set
  task automatic meas(int ch, bit pend, logic [7:0] d);
    logic [7:0] r;
    logic [7:0] dif;
    logic       hit;
    r   = m_cfg[ch][0] ? m_avg[ch] : m_ref[ch];
    dif = (d > r) ? d - r : r - d;
    hit = pend && (dif > {4'h0, m_cfg[ch][7:4]});
    wake_amp_en   = (ch == 0);
    wake_phase_en = (ch == 1);
    if (pend) begin
      timer_expired = 1'b1;
      @(negedge sys_clk);
      timer_expired = 1'b0;
      chk1("amp_meas_start", ch == 0, amp_meas_start);
      chk1("phase_meas_start", ch == 1, phase_meas_start);
    end
    repeat ($urandom_range(2)) @(negedge sys_clk);
    amp_meas_valid   = (ch == 0);
    phase_meas_valid = (ch == 1);
    amp_meas_data    = d;
    phase_meas_data  = d;
    @(negedge sys_clk);
    amp_meas_valid   = 1'b0;
    phase_meas_valid = 1'b0;
    chk1("amp_irq", hit && ch == 0, amp_irq);
    chk1("phase_irq", hit && ch == 1, phase_irq);
    m_res[ch] = d;
    // a sample over threshold only counts when the include bit allows it
    if (pend && (!hit || m_cfg[ch][3]))
      m_avg[ch] = nxt_avg(m_avg[ch], d, m_cfg[ch][2:1]);
    if (ch == 0) begin
      rdchk("amplitude_result_value", wumc_pkg::AMP_RES_OFS, m_res[0]);
      rdchk("amplitude_average_value", wumc_pkg::AMP_AVG_OFS, m_avg[0]);
    end else begin
      rdchk("phase_result_value", wumc_pkg::PH_RES_OFS, m_res[1]);
      rdchk("phase_average_value", wumc_pkg::PH_AVG_OFS, m_avg[1]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the roughly 1200 cycles the tests need at most
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] c;
    int         ch;
    {rst, clk_en, reg_wr, reg_rd, set_default, timer_expired} = 6'h30;
    {wake_amp_en, wake_phase_en, amp_meas_valid, phase_meas_valid} = 4'h0;
    {reg_addr, reg_wdata, amp_cfg, amp_ref, amp_meas_data, phase_meas_data} = '0;
    miscompares = 0;
    checks_done = 0;
    for (int i = 0; i < 2; i++) {m_avg[i], m_res[i], m_cfg[i], m_ref[i]} = '0;
    void'($urandom(83));
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    // reset values, then writes to read-only places must leave them alone
    for (int a = 'h34; a <= 'h3d; a++) rdchk("reset_value", 6'(a), 8'h00);
    for (int a = 'h34; a <= 'h3d; a++) if (a != 'h36 && a != 'h37) begin
      wr(6'(a), 8'hff);
      @(negedge sys_clk);
    end
    for (int a = 'h34; a <= 'h3d; a++) rdchk("read_only", 6'(a), 8'h00);
    rdchk("unmapped", 6'h10, wumc_pkg::UNMAPPED);
    // every weight code with include off and on, threshold 2, average reference
    for (int k = 0; k < 8; k++) begin
      set_phase_cfg({4'h2, k[0], k[2:1], 1'b1}, 8'h40);
      meas(1, 1'b1, 8'(k * 37 + 5));
      meas(1, 1'b1, m_avg[1] + 8'h01);
    end
    // clock enable low: a write in that cycle must not land
    clk_en = 1'b0;
    wr(wumc_pkg::PH_REF_OFS, 8'h5a);
    clk_en = 1'b1;
    rdchk("frozen_write", wumc_pkg::PH_REF_OFS, m_ref[1]);
    // random configurations and samples on both channels
    for (int i = 0; i < 60; i++) begin
      ch = $urandom_range(1);
      if ($urandom_range(3) == 0) begin
        c = 8'($urandom);
        if (ch == 0) begin
          amp_cfg  = c;
          amp_ref  = 8'($urandom);
          m_cfg[0] = c;
          m_ref[0] = amp_ref;
        end else
          set_phase_cfg(c, 8'($urandom));
      end
      if ($urandom_range(1) == 1)
        c = 8'($urandom);
      else
        c = 8'(int'(m_cfg[ch][0] ? m_avg[ch] : m_ref[ch]) + $urandom_range(30) - 15);
      meas(ch, $urandom_range(3) != 0, c);
    end
    // set-default clears display, configuration and reference, and beats a write
    set_default = 1'b1;
    wr(wumc_pkg::PH_REF_OFS, 8'h77);
    set_default = 1'b0;
    for (int i = 0; i < 2; i++) {m_avg[i], m_res[i]} = '0;
    {m_cfg[1], m_ref[1]} = '0;
    for (int a = 'h34; a <= 'h39; a++) rdchk("set_default", 6'(a), 8'h00);
    meas(0, 1'b1, 8'h9c);
    meas(1, 1'b1, 8'h05);
    end_sim();
  end
endmodule // wumc_regs_tb
